/* src/spdb_pkg.sv */
package spdb_pkg;

  // Register byte addresses as seen on the register port
  localparam logic [15:0] ADDR_FRAME_FORMAT = 16'hffa8;
  localparam logic [15:0] ADDR_BAUD_DIVISOR = 16'hffa9;
  localparam logic [15:0] ADDR_SERIAL_CTRL  = 16'hffaa;
  localparam logic [15:0] ADDR_TX_HOLDING   = 16'hffab;
  localparam logic [15:0] ADDR_SERIAL_STAT  = 16'hffac;
  localparam logic [15:0] ADDR_RX_HOLDING   = 16'hffad;
  localparam logic [15:0] ADDR_IRQ_STATUS   = 16'hffae;
  localparam logic [15:0] ADDR_IRQ_MASK     = 16'hffaf;

  // Values after reset
  localparam logic [7:0] RST_TX_HOLDING   = 8'hff;
  localparam logic [7:0] RST_RX_HOLDING   = 8'h00;
  localparam logic [7:0] RST_FRAME_FORMAT = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'hff;
  localparam logic [7:0] RST_SERIAL_CTRL  = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK     = 8'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // Bit positions in serial_control
  localparam int CTRL_TX_EN = 5;
  localparam int CTRL_RX_EN = 4;

  // Bit positions in serial_status (reserved bits read zero)
  localparam int STAT_TX_EMPTY = 7;
  localparam int STAT_RX_FULL  = 6;
  localparam int STAT_OVERRUN  = 5;
  localparam int STAT_FRAMING  = 4;
  localparam int STAT_TX_END   = 2;

  // Bit positions in irq_status and irq_mask
  localparam int IRQ_RX_FULL  = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_OVERRUN  = 2;
  localparam int IRQ_FRAMING  = 3;
  localparam int IRQ_TX_END   = 4;
  localparam int IRQ_COUNT    = 5;

  // Index of the last data bit in one frame
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // Serial line states, Gray coded along the frame
  typedef enum logic [1:0] {
    SPDB_IDLE  = 2'b00,
    SPDB_START = 2'b01,
    SPDB_DATA  = 2'b11,
    SPDB_STOP  = 2'b10
  } spdb_line_e;

  // One register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } spdb_req_s;

endpackage : spdb_pkg

/* src/spdb_serial.sv */
`timescale 1ns/1ps

module spdb_serial (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rd_data_out,
  input  wire logic        rx_pin_in,
  output logic             tx_pin_out,
  output logic             irq_out
);

  // Bundle the register port request
  spdb_pkg::spdb_req_s req;
  assign req = '{addr: addr_in, wdata: wr_data_in, wr: wr_in, rd: rd_in};

  // Software visible registers
  logic [7:0] frame_format;
  logic [7:0] baud_divisor;
  logic [7:0] serial_control;
  logic [7:0] tx_holding;
  logic [7:0] rx_holding;
  logic [7:0] irq_mask;
  logic [spdb_pkg::IRQ_COUNT-1:0] irq_status;
  logic       tx_empty_flag;
  logic       rx_full_flag;
  logic       overrun_flag;
  logic       framing_flag;
  logic       tx_end_flag;

  // Hidden datapath state
  logic [7:0] receive_shift_reg;
  logic [7:0] transmit_shift_reg;
  logic [7:0] rx_cnt;
  logic [7:0] tx_cnt;
  logic [2:0] rx_bit;
  logic [2:0] tx_bit;
  logic       rx_meta;
  logic       rx_sync;
  spdb_pkg::spdb_line_e rx_state;
  spdb_pkg::spdb_line_e tx_state;

  // Address decode; shift registers have no address at all
  wire sel_format = req.addr == spdb_pkg::ADDR_FRAME_FORMAT;
  wire sel_baud   = req.addr == spdb_pkg::ADDR_BAUD_DIVISOR;
  wire sel_ctrl   = req.addr == spdb_pkg::ADDR_SERIAL_CTRL;
  wire sel_txh    = req.addr == spdb_pkg::ADDR_TX_HOLDING;
  wire sel_stat   = req.addr == spdb_pkg::ADDR_SERIAL_STAT;
  wire sel_rxh    = req.addr == spdb_pkg::ADDR_RX_HOLDING;
  wire sel_istat  = req.addr == spdb_pkg::ADDR_IRQ_STATUS;
  wire sel_imask  = req.addr == spdb_pkg::ADDR_IRQ_MASK;

  wire wr_format  = req.wr && sel_format;
  wire wr_baud    = req.wr && sel_baud;
  wire wr_ctrl    = req.wr && sel_ctrl;
  wire wr_txh     = req.wr && sel_txh;
  wire wr_stat    = req.wr && sel_stat;
  wire wr_imask   = req.wr && sel_imask;
  wire rd_rxh     = req.rd && sel_rxh;
  wire rd_istat   = req.rd && sel_istat;

  wire tx_en      = serial_control[spdb_pkg::CTRL_TX_EN];
  wire rx_en      = serial_control[spdb_pkg::CTRL_RX_EN];

  // Status image; reserved bits read zero
  wire [7:0] status_image;
  assign status_image = {tx_empty_flag, rx_full_flag, overrun_flag, framing_flag,
                         1'b0, tx_end_flag, 2'b00};

  // Read multiplexer; unmapped addresses read zero
  wire [7:0] next_rd_data =
    sel_format ? frame_format :
    sel_baud   ? baud_divisor :
    sel_ctrl   ? serial_control :
    sel_txh    ? tx_holding :
    sel_stat   ? status_image :
    sel_rxh    ? rx_holding :
    sel_istat  ? {3'b000, irq_status} :
    sel_imask  ? irq_mask : spdb_pkg::READ_ZERO;

  // Read data stands only in the cycle after the strobe
  logic [7:0] rd_data;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      rd_data <= spdb_pkg::READ_ZERO;
    else
      rd_data <= req.rd ? next_rd_data : spdb_pkg::READ_ZERO;
  end
  assign rd_data_out = rd_data;

  // Plain configuration registers
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      frame_format   <= spdb_pkg::RST_FRAME_FORMAT;
      baud_divisor   <= spdb_pkg::RST_BAUD_DIVISOR;
      serial_control <= spdb_pkg::RST_SERIAL_CTRL;
      irq_mask       <= spdb_pkg::RST_IRQ_MASK;
    end
    else
    begin
      if (wr_format) frame_format <= req.wdata;
      if (wr_baud) baud_divisor <= req.wdata;
      if (wr_ctrl) serial_control <= req.wdata;
      if (wr_imask) irq_mask <= req.wdata;
    end
  end

  // Receive pin passes two flops before anything looks at it
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_pin_in;
      rx_sync <= rx_meta;
    end
  end

  // Receive timing: one bit lasts baud_divisor+1 cycles, sampled mid-bit
  wire rx_tick      = rx_cnt == 8'h00;
  wire rx_frame_end = rx_state == spdb_pkg::SPDB_STOP && rx_tick;
  wire rx_move      = rx_frame_end && !rx_full_flag;
  wire rx_overrun   = rx_frame_end && rx_full_flag;
  wire rx_bad_stop  = rx_frame_end && !rx_sync;

  // Receive line sequencer
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_state          <= spdb_pkg::SPDB_IDLE;
      rx_cnt            <= 8'h00;
      rx_bit            <= 3'h0;
      receive_shift_reg <= 8'h00;
    end
    else
    begin
      rx_cnt <= rx_tick ? baud_divisor : rx_cnt - 8'h01;
      unique case (rx_state)
        spdb_pkg::SPDB_IDLE:
          if (rx_en && !rx_sync)
          begin
            rx_state <= spdb_pkg::SPDB_START;
            rx_cnt   <= {1'b0, baud_divisor[7:1]};
          end
        spdb_pkg::SPDB_START:
          if (rx_tick)
          begin
            rx_state <= rx_sync ? spdb_pkg::SPDB_IDLE : spdb_pkg::SPDB_DATA;
            rx_bit   <= 3'h0;
          end
        spdb_pkg::SPDB_DATA:
          if (rx_tick)
          begin
            receive_shift_reg <= {rx_sync, receive_shift_reg[7:1]};
            rx_bit            <= rx_bit + 3'h1;
            if (rx_bit == spdb_pkg::LAST_DATA_BIT)
              rx_state <= spdb_pkg::SPDB_STOP;
          end
        spdb_pkg::SPDB_STOP:
          if (rx_tick)
            rx_state <= spdb_pkg::SPDB_IDLE;
      endcase
    end
  end

  // Receive holding and its flags; hardware set wins over software clear
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_holding   <= spdb_pkg::RST_RX_HOLDING;
      rx_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      framing_flag <= 1'b0;
    end
    else
    begin
      if (rx_move)
        rx_holding <= receive_shift_reg;
      rx_full_flag <= rx_move | (rx_full_flag & ~rd_rxh);
      overrun_flag <= rx_overrun |
                      (overrun_flag & ~(wr_stat & ~req.wdata[spdb_pkg::STAT_OVERRUN]));
      framing_flag <= rx_bad_stop |
                      (framing_flag & ~(wr_stat & ~req.wdata[spdb_pkg::STAT_FRAMING]));
    end
  end

  // Transmit timing and the load from holding into the shift register
  wire tx_tick  = tx_cnt == 8'h00;
  wire tx_idle  = tx_state == spdb_pkg::SPDB_IDLE;
  wire tx_done  = tx_state == spdb_pkg::SPDB_STOP && tx_tick;
  wire tx_load  = tx_en && !tx_empty_flag && (tx_idle || tx_done);
  wire tx_final = tx_done && tx_empty_flag;

  // Transmit line sequencer, least significant bit first
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      tx_state           <= spdb_pkg::SPDB_IDLE;
      tx_cnt             <= 8'h00;
      tx_bit             <= 3'h0;
      transmit_shift_reg <= 8'h00;
      tx_pin_out         <= 1'b1;
    end
    else
    begin
      tx_cnt <= tx_tick ? baud_divisor : tx_cnt - 8'h01;
      unique case (tx_state)
        spdb_pkg::SPDB_IDLE:
          tx_pin_out <= 1'b1;
        spdb_pkg::SPDB_START:
          if (tx_tick)
          begin
            tx_state   <= spdb_pkg::SPDB_DATA;
            tx_pin_out <= transmit_shift_reg[0];
            tx_bit     <= 3'h0;
          end
        spdb_pkg::SPDB_DATA:
          if (tx_tick)
          begin
            transmit_shift_reg <= {1'b1, transmit_shift_reg[7:1]};
            tx_bit             <= tx_bit + 3'h1;
            if (tx_bit == spdb_pkg::LAST_DATA_BIT)
            begin
              tx_state   <= spdb_pkg::SPDB_STOP;
              tx_pin_out <= 1'b1;
            end
            else
              tx_pin_out <= transmit_shift_reg[1];
          end
        spdb_pkg::SPDB_STOP:
          if (tx_tick)
            tx_state <= spdb_pkg::SPDB_IDLE;
      endcase
      // A load overrides the idle return so frames follow back to back
      if (tx_load)
      begin
        transmit_shift_reg <= tx_holding;
        tx_state           <= spdb_pkg::SPDB_START;
        tx_cnt             <= baud_divisor;
        tx_pin_out         <= 1'b0;
      end
    end
  end

  // Transmit holding and its flags; the load sets empty, a write clears it
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      tx_holding    <= spdb_pkg::RST_TX_HOLDING;
      tx_empty_flag <= 1'b1;
      tx_end_flag   <= 1'b1;
    end
    else
    begin
      if (wr_txh)
        tx_holding <= req.wdata;
      tx_empty_flag <= tx_load | (tx_empty_flag & ~wr_txh);
      tx_end_flag   <= tx_final | (tx_end_flag & ~tx_load);
    end
  end

  // Event pulses into the sticky interrupt status
  wire [spdb_pkg::IRQ_COUNT-1:0] irq_event;
  assign irq_event[spdb_pkg::IRQ_RX_FULL]  = rx_move;
  assign irq_event[spdb_pkg::IRQ_TX_EMPTY] = tx_load;
  assign irq_event[spdb_pkg::IRQ_OVERRUN]  = rx_overrun;
  assign irq_event[spdb_pkg::IRQ_FRAMING]  = rx_bad_stop;
  assign irq_event[spdb_pkg::IRQ_TX_END]   = tx_final;

  // Reading the status clears it, but an event in that cycle survives
  wire [spdb_pkg::IRQ_COUNT-1:0] next_irq_status;
  genvar gi;
  generate
    for (gi = 0; gi < spdb_pkg::IRQ_COUNT; gi++)
    begin : g_irq
      assign next_irq_status[gi] = irq_event[gi] | (irq_status[gi] & ~rd_istat);
    end
  endgenerate

  // One process owns the whole sticky vector, so no bit has two writers
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      irq_status <= {spdb_pkg::IRQ_COUNT{1'b0}};
    else
      irq_status <= next_irq_status;
  end

  // Level interrupt while any unmasked sticky bit is set
  assign irq_out = |(irq_status & irq_mask[spdb_pkg::IRQ_COUNT-1:0]);

endmodule : spdb_serial

/* tb/spdb_peer.sv */
`timescale 1ns/1ps
module spdb_peer (
  input  wire logic ref_clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  int         bit_cyc = 4; // Matches baud divisor 3 set by the bench
  logic [7:0] got_q[$];

  // Line idles high as if pulled up
  initial line_out = 1'b1;

  // Send one 8N1 frame, least significant bit first
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (bit_cyc) @(posedge ref_clk_in);
    end
  endtask : send

  // Frame with a low stop bit, then the line goes back to idle high
  task automatic send_bad(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b0, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (bit_cyc) @(posedge ref_clk_in);
    end
    line_out <= 1'b1;
    repeat (bit_cyc) @(posedge ref_clk_in);
  endtask : send_bad

  // Sample device frames mid bit; a bad stop bit drops the byte so the bench notices
  initial
  begin : grab
    logic [7:0] b;
    forever
    begin
      @(negedge line_in);
      repeat (bit_cyc / 2) @(posedge ref_clk_in);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_cyc) @(posedge ref_clk_in);
        b[i] = line_in;
      end
      repeat (bit_cyc) @(posedge ref_clk_in);
      if (line_in === 1'b1)
        got_q.push_back(b);
    end
  end
endmodule : spdb_peer

/* tb/spdb_serial_monitor.sv */
`timescale 1ns/1ps
module spdb_serial_monitor (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wr_data_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rd_data_out,
  input wire logic        rx_pin_in,
  input wire logic        tx_pin_out,
  input wire logic        irq_out
);
  logic [7:0]  div, ctrl, tx_hold;
  logic        armed;
  logic [11:0] run;
  wire         wr_tx = wr_in && addr_in == 16'hffab;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Shadow of the written registers, since only the port is visible here
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      div     <= 8'hff;
      ctrl    <= 8'h00;
      tx_hold <= 8'hff;
      armed   <= 1'b0;
    end
    else if (wr_in)
    begin
      if (addr_in == 16'hffa9) div <= wr_data_in;
      if (addr_in == 16'hffaa) ctrl <= wr_data_in;
      if (wr_tx) tx_hold <= wr_data_in;
      if (wr_tx) armed <= 1'b1;
    end
  end

  // Cycles since the transmit pin last changed; a low run must be whole bit times
  always_ff @(posedge ref_clk_in)
    run <= $changed(tx_pin_out) ? 12'h001 : run + 12'h001;

  // First byte after reset with the transmitter enabled starts a frame at once
  sequence first_tx_write;
    !armed && wr_tx && ctrl[5];
  endsequence
  sequence start_bit_soon;
    ##[1:3] !tx_pin_out;
  endsequence

  chk_read_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
    else $error("read data not zero outside the read answer cycle");
  chk_unmapped_read: assert property (rd_in && (addr_in < 16'hffa8 || addr_in > 16'hffaf) |=> rd_data_out == 8'h00)
    else $error("unmapped read returned data");
  chk_txhold_readback: assert property (rd_in && addr_in == 16'hffab |=> rd_data_out == $past(tx_hold))
    else $error("transmit holding readback wrong");
  chk_tx_reset_idle: assert property ($rose(rst_n_in) |-> tx_pin_out && !irq_out)
    else $error("line or interrupt active right after reset");
  chk_tx_wait_data: assert property (!armed |-> tx_pin_out)
    else $error("transmit started without a written byte");
  chk_first_start: assert property (first_tx_write |-> start_bit_soon)
    else $error("start bit missing after first byte");
  chk_low_run_bits: assert property ($rose(tx_pin_out) |-> run % ({4'h0, div} + 12'h001) == 12'h000)
    else $error("low run on transmit pin not whole bit times");
  chk_start_stable: assert property ($fell(tx_pin_out) && div != 8'h00 |=> !tx_pin_out)
    else $error("start bit shorter than a bit time");
endmodule : spdb_serial_monitor

bind spdb_serial spdb_serial_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .rx_pin_in(rx_pin_in),
  .tx_pin_out(tx_pin_out), .irq_out(irq_out));

/* tb/spdb_serial_tb.sv */
`timescale 1ns/1ps
module spdb_serial_tb;
  logic        ref_clk_in, rst_n_in, wr_in, rd_in, rx_pin_in, tx_pin_out, irq_out;
  logic [15:0] addr_in;
  logic [7:0]  wr_data_in, rd_data_out, d;
  int          err_count, cmp_count;

  spdb_serial u_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .rx_pin_in(rx_pin_in), .tx_pin_out(tx_pin_out),
    .irq_out(irq_out));
  spdb_peer u_peer (.ref_clk_in(ref_clk_in), .line_in(tx_pin_out), .line_out(rx_pin_in));

  // 40 MHz clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    wr_in      <= 1'b1;
    addr_in    <= a;
    wr_data_in <= v;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr_reg

  // Data stands only in the cycle after the strobe, so sample it there
  task automatic rd_reg(input logic [15:0] a);
    @(posedge ref_clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rd_data_out;
  endtask : rd_reg

  task automatic wait_irq;
    for (int i = 0; i < 400 && irq_out !== 1'b1; i++)
      @(posedge ref_clk_in);
    check("irq_out", {7'h00, irq_out}, 8'h01);
  endtask : wait_irq

  task automatic t_regs;
    rd_reg(16'hffab);
    check("tx_holding", d, 8'hff);
    rd_reg(16'hffac);
    check("status", d, 8'h84);
    wr_reg(16'hffad, 8'h5a);
    rd_reg(16'hffad);
    check("rx_holding", d, 8'h00);
    rd_reg(16'hffb0);
    check("unmapped", d, 8'h00);
  endtask : t_regs

  // Second byte written mid-frame must arrive intact after the first
  task automatic t_transmit;
    wr_reg(16'hffa9, 8'h03);
    wr_reg(16'hffaa, 8'h30);
    wr_reg(16'hffaf, 8'h01);
    wr_reg(16'hffab, 8'ha5);
    rd_reg(16'hffac);
    check("tx_empty", d & 8'h80, 8'h80);
    wr_reg(16'hffab, 8'h3c);
    for (int i = 0; i < 400 && u_peer.got_q.size() < 2; i++)
      @(posedge ref_clk_in);
    check("frame0", u_peer.got_q[0], 8'ha5);
    check("frame1", u_peer.got_q[1], 8'h3c);
  endtask : t_transmit

  // Two frames back to back; the first is read while the second arrives
  task automatic t_receive;
    fork
      begin
        u_peer.send(8'h96);
        u_peer.send(8'h69);
      end
    join_none
    wait_irq;
    rd_reg(16'hffac);
    check("rx_full", d & 8'h40, 8'h40);
    rd_reg(16'hffae);
    check("irq_status", d, 8'h13);
    check("irq_clear", {7'h00, irq_out}, 8'h00);
    rd_reg(16'hffad);
    check("rx_byte0", d, 8'h96);
    wait_irq;
    rd_reg(16'hffac);
    check("rx_full1", d & 8'h40, 8'h40);
    rd_reg(16'hffad);
    check("rx_byte1", d, 8'h69);
    rd_reg(16'hffac);
    check("overrun", d & 8'h20, 8'h00);
  endtask : t_receive

  // Unread byte survives a second frame; a low stop bit flags framing; disabled receiver ignores the line
  task automatic t_errors;
    u_peer.send(8'h11);
    u_peer.send(8'h22);
    repeat (8) @(posedge ref_clk_in);
    rd_reg(16'hffac);
    check("overrun_set", d, 8'he4);
    rd_reg(16'hffad);
    check("kept_byte", d, 8'h11);
    wr_reg(16'hffac, 8'h00);
    u_peer.send_bad(8'h33);
    repeat (8) @(posedge ref_clk_in);
    rd_reg(16'hffac);
    check("framing_set", d, 8'hd4);
    rd_reg(16'hffad);
    check("bad_stop_byte", d, 8'h33);
    wr_reg(16'hffaa, 8'h20);
    u_peer.send(8'h44);
    repeat (8) @(posedge ref_clk_in);
    rd_reg(16'hffac);
    check("rx_disabled", d & 8'h40, 8'h00);
  endtask : t_errors

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial
  begin
    rst_n_in   = 1'b0;
    addr_in    = 16'h0000;
    wr_data_in = 8'h00;
    wr_in      = 1'b0;
    rd_in      = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_transmit;
    t_receive;
    t_errors;
    stop_test;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    err_count++;
    stop_test;
  end
endmodule : spdb_serial_tb
